// ### design/gpec_pkg.sv
package gpec_pkg;

    // ------------------------------------------------------------
    // Clock and timebase
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ     = 25_000_000;
    localparam int unsigned TB16_F1    = 1_000_000;
    localparam int unsigned TB16_F2    = 100_000;
    localparam int unsigned TB16_F3    = 10_000;
    localparam int unsigned TB16_F4    = 1_000;
    localparam int unsigned TB16_F5    = 100;
    localparam int unsigned TB24_F1    = 20_000_000;
    localparam int unsigned TB24_F2    = 100_000;
    localparam logic [31:0] MIN_PHASE  = 32'h0000_0003;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CMD     = 5'h00;
    localparam logic [4:0] OFS_MODE    = 5'h04;
    localparam logic [4:0] OFS_DELAY   = 5'h08;
    localparam logic [4:0] OFS_PULSE   = 5'h0C;
    localparam logic [4:0] OFS_COUNT   = 5'h10;
    localparam logic [4:0] OFS_STATUS  = 5'h14;
    localparam logic [4:0] OFS_CNT_HI  = 5'h18;
    localparam logic [4:0] OFS_PARTNER = 5'h1C;
    localparam int         CMD_GO_BIT  = 0;
    localparam int         CMD_HALT_BIT = 1;

    // ------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------
    localparam logic [2:0] GATE_IGNORED = 3'h0;
    localparam logic [2:0] GATE_HIGH    = 3'h1;
    localparam logic [2:0] GATE_LOW     = 3'h2;
    localparam logic [2:0] GATE_RISE    = 3'h3;
    localparam logic [2:0] GATE_FALL    = 3'h4;
    localparam logic [2:0] SRC_PIN      = 3'h0;
    localparam logic [31:0] LEN_RST     = 32'h0000_0003;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} gpec_run_e;

    // Packed from bit 10 down to bit 0, matching the MODE word
    typedef struct packed {
        logic       pulse_train;       // 1 pulse_train_setup
        logic [2:0] gate_behaviour;
        logic       output_polarity;   // 0 pulse_active_high
        logic [2:0] count_source_select;
        logic       increment_edge;    // 0 rising, 1 falling
        logic       terminal_action;   // 0 stop_at_terminal, 1 continuous
        logic       two_counters;      // counter_width: cascade pair
    } gpec_mode_s;

    localparam gpec_mode_s MODE_RST = '0;

    typedef struct packed {
        logic       waitreq;
        logic [31:0] rdata;
        gpec_run_e  run;
        gpec_mode_s mode;
        logic [31:0] delay_len;
        logic [31:0] pulse_len;
        logic [31:0] cnt;
        logic [15:0] snap_hi;
        logic       overflow;
        logic       phase;
        logic       out;
        logic [2:0] src_sync;
        logic       src_filt;
        logic       src_prev;
        logic [2:0] gate_sync;
        logic       gate_filt;
        logic       gate_prev;
        logic [31:0] tb_acc;
        logic       tb_lvl;
        logic       tb_prev;
    } gpec_state_s;

    localparam int          STATE_W   = $bits(gpec_state_s);
    localparam gpec_state_s STATE_RST = gpec_state_s'({1'b1, {(STATE_W-1){1'b0}}});

endpackage

// ### design/gpec_counter.sv
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - Output period is a delay phase then a pulse phase; equal lengths give a square wave.
// - Pulse phase length below three timebase cycles is raised to three.
// - Delay phase length below three timebase cycles is raised to three.
// - Gate ignored mode runs as soon as software issues go.
// - Level-high gate mode advances only while gate is high.
// - Level-low gate mode advances only while gate is low.
// - Rising trigger mode waits after go for the first gate rising edge.
// - Falling trigger mode waits after go for the first gate falling edge.
// - Active-high polarity: output low in delay phase, high in pulse phase.
// - Active-low polarity: output high in delay phase, low in pulse phase.
// - Source selector picks source pin edges or internal timebase cycles.
// - Timebase choices depend on the 16-bit or 24-bit variant.
// - Counter increments only on the selected rising or falling edge.
// - Stop-at-terminal mode halts and flags overflow; 16-bit variant only.
// - Continuous mode wraps; only the 24-bit variant flags overflow.
// - 24-bit variant is single; 16-bit variant may cascade to 32 bits.
// - Cascade partner is the next counter in its group of five, wrapping.
// - Gate or trigger behaviour is armed only after the go command.
// - Pulse train counts down delay length, then pulse length, repeatedly.
// - Count read returns current value plus overflow indication; here the count word holds only the value, overflow is read from status.
module gpec_counter
    import gpec_pkg::*;
#(
    parameter bit VARIANT24  = 1'b0,   // 0: 16-bit family, 1: 24-bit family
    parameter int CHANNEL_ID = 1       // Position 1..10 among the counters
) (
    input  wire logic        I_CLOCK,       // System clock, 25 MHz
    input  wire logic        I_ARST_N,      // Asynchronous reset, active low
    input  wire logic        I_CE,          // Clock enable, freezes all state
    input  wire logic [4:0]  I_ADDRESS,     // Avalon byte address
    input  wire logic        I_READ,        // Avalon read
    input  wire logic        I_WRITE,       // Avalon write
    input  wire logic [31:0] I_WRITEDATA,   // Avalon write data
    input  wire logic [3:0]  I_BYTEENABLE,  // Avalon byte enables
    output logic      [31:0] O_READDATA,    // Avalon read data
    output logic             O_WAITREQUEST, // Avalon wait request
    input  wire logic        I_SOURCE,      // External count source pin
    input  wire logic        I_GATE,        // External gate pin
    output logic             O_OUT          // Pulse output pin
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (CHANNEL_ID < 1 || CHANNEL_ID > 10) begin : g_bad_id
        $error("CHANNEL_ID must be 1 to 10");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] width_mask(input logic two);
        if (VARIANT24)
            width_mask = 32'h00FF_FFFF;
        else if (two)
            width_mask = 32'hFFFF_FFFF;
        else
            width_mask = 32'h0000_FFFF;
    endfunction

    // Short phases are stretched to the minimum the hardware can time
    function automatic logic [31:0] phase_len(input logic [31:0] len,
                                              input logic [31:0] mask);
        phase_len = ((len & mask) < MIN_PHASE) ? MIN_PHASE : (len & mask);
    endfunction

    function automatic logic [31:0] tb_freq(input logic [2:0] sel);
        tb_freq = 32'h0000_0000;
        if (VARIANT24) begin
            case (sel)
                3'h1:    tb_freq = 32'(TB24_F1);
                3'h2:    tb_freq = 32'(TB24_F2);
                default: tb_freq = 32'h0000_0000;
            endcase
        end else begin
            case (sel)
                3'h1:    tb_freq = 32'(TB16_F1);
                3'h2:    tb_freq = 32'(TB16_F2);
                3'h3:    tb_freq = 32'(TB16_F3);
                3'h4:    tb_freq = 32'(TB16_F4);
                3'h5:    tb_freq = 32'(TB16_F5);
                default: tb_freq = 32'h0000_0000;
            endcase
        end
    endfunction

    function automatic logic [31:0] partner_of(input int id);
        partner_of = (id == 5) ? 32'h0000_0001 :
                     (id == 10) ? 32'h0000_0006 : 32'(id + 1);
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        be_merge = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i])
                be_merge[8*i +: 8] = wd[8*i +: 8];
        end
    endfunction

    function automatic logic idle_level(input logic pol);
        idle_level = pol;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    gpec_state_s s;
    gpec_state_s n;

    logic [31:0] mask;
    logic [31:0] step;
    logic [31:0] acc_sum;
    logic        src_rise;
    logic        src_fall;
    logic        gate_rise;
    logic        gate_fall;
    logic        tb_rise;
    logic        tb_fall;
    logic        edge_hit;
    logic        gate_ok;
    logic        trig;
    logic        is_trig_mode;
    logic        stop_mode;
    logic        ack;
    logic [31:0] wmerged;

    always_comb begin
        n = s;
        mask = width_mask(s.mode.two_counters);
        ack = ~s.waitreq;
        wmerged = 32'h0000_0000;

        // --------------------------------------------------------
        // Pin synchronisers: 2nd and 3rd stage must agree
        // --------------------------------------------------------
        n.src_sync = {s.src_sync[1:0], I_SOURCE};
        n.gate_sync = {s.gate_sync[1:0], I_GATE};
        if (s.src_sync[1] == s.src_sync[2])
            n.src_filt = s.src_sync[2];
        if (s.gate_sync[1] == s.gate_sync[2])
            n.gate_filt = s.gate_sync[2];
        n.src_prev = s.src_filt;
        n.gate_prev = s.gate_filt;
        src_rise = s.src_filt & ~s.src_prev;
        src_fall = ~s.src_filt & s.src_prev;
        gate_rise = s.gate_filt & ~s.gate_prev;
        gate_fall = ~s.gate_filt & s.gate_prev;

        // --------------------------------------------------------
        // Internal timebase: toggles at twice the selected rate
        // --------------------------------------------------------
        // A 20 MHz base cannot toggle faster than the clock, so it
        // saturates at one edge per clock cycle.
        step = tb_freq(s.mode.count_source_select) << 1;
        acc_sum = s.tb_acc + step;
        n.tb_prev = s.tb_lvl;
        if (step == 32'h0000_0000) begin
            n.tb_acc = 32'h0000_0000;
        end else if (step >= 32'(CLK_HZ)) begin
            n.tb_acc = 32'h0000_0000;
            n.tb_lvl = ~s.tb_lvl;
        end else if (acc_sum >= 32'(CLK_HZ)) begin
            n.tb_acc = acc_sum - 32'(CLK_HZ);
            n.tb_lvl = ~s.tb_lvl;
        end else begin
            n.tb_acc = acc_sum;
        end
        tb_rise = s.tb_lvl & ~s.tb_prev;
        tb_fall = ~s.tb_lvl & s.tb_prev;

        // --------------------------------------------------------
        // Counted edge selection
        // --------------------------------------------------------
        if (s.mode.count_source_select == SRC_PIN)
            edge_hit = s.mode.increment_edge ? src_fall : src_rise;
        else
            edge_hit = s.mode.increment_edge ? tb_fall : tb_rise;

        // --------------------------------------------------------
        // Gate qualification
        // --------------------------------------------------------
        case (s.mode.gate_behaviour)
            GATE_HIGH: gate_ok = s.gate_filt;
            GATE_LOW:  gate_ok = ~s.gate_filt;
            default:   gate_ok = 1'b1;
        endcase
        case (s.mode.gate_behaviour)
            GATE_RISE: trig = gate_rise;
            GATE_FALL: trig = gate_fall;
            default:   trig = 1'b0;
        endcase
        is_trig_mode = (s.mode.gate_behaviour == GATE_RISE) ||
                       (s.mode.gate_behaviour == GATE_FALL);
        // Stop-at-terminal does not exist on the 24-bit family
        stop_mode = ~s.mode.terminal_action & ~VARIANT24;

        // --------------------------------------------------------
        // Counter engine
        // --------------------------------------------------------
        case (s.run)
            ST_IDLE: begin
            end
            ST_ARMED: begin
                if (trig)
                    n.run = ST_RUN;
            end
            ST_RUN: begin
                if (edge_hit && gate_ok) begin
                    if (s.mode.pulse_train) begin
                        if (s.cnt <= 32'h0000_0001) begin
                            n.phase = ~s.phase;
                            n.cnt = s.phase ? phase_len(s.delay_len, mask)
                                            : phase_len(s.pulse_len, mask);
                            n.out = s.phase ? idle_level(s.mode.output_polarity)
                                            : ~idle_level(s.mode.output_polarity);
                        end else begin
                            n.cnt = s.cnt - 32'h0000_0001;
                        end
                    end else if (stop_mode) begin
                        if (((s.cnt + 32'h0000_0001) & mask) == mask) begin
                            n.cnt = mask;
                            n.overflow = 1'b1;
                            n.run = ST_IDLE;
                        end else begin
                            n.cnt = (s.cnt + 32'h0000_0001) & mask;
                        end
                    end else begin
                        n.cnt = (s.cnt + 32'h0000_0001) & mask;
                        if (s.cnt == mask && VARIANT24)
                            n.overflow = 1'b1;
                    end
                end
            end
            default: n.run = ST_IDLE;
        endcase

        // --------------------------------------------------------
        // Avalon slave: one wait cycle, then the access completes
        // --------------------------------------------------------
        n.waitreq = 1'b1;
        if ((I_READ || I_WRITE) && s.waitreq)
            n.waitreq = 1'b0;

        if (I_READ && s.waitreq) begin
            case (I_ADDRESS)
                OFS_CMD:     n.rdata = 32'h0000_0000;
                OFS_MODE:    n.rdata = 32'(s.mode);
                OFS_DELAY:   n.rdata = s.delay_len;
                OFS_PULSE:   n.rdata = s.pulse_len;
                OFS_COUNT: begin
                    // Upper half frozen with the same edge as the low word
                    n.rdata = s.cnt & mask;
                    n.snap_hi = s.cnt[31:16];
                end
                OFS_STATUS:  n.rdata = {28'h000_0000, s.out, (s.run == ST_ARMED),
                                        (s.run == ST_RUN), s.overflow};
                OFS_CNT_HI:  n.rdata = {16'h0000, s.snap_hi};
                OFS_PARTNER: n.rdata = VARIANT24 ? 32'h0000_0000
                                                 : partner_of(CHANNEL_ID);
                default:     n.rdata = 32'h0000_0000;
            endcase
        end

        if (I_WRITE && ack) begin
            case (I_ADDRESS)
                OFS_CMD: begin
                    if (I_BYTEENABLE[0] && I_WRITEDATA[CMD_HALT_BIT]) begin
                        n.run = ST_IDLE;
                        n.overflow = 1'b0;
                        n.phase = 1'b0;
                        n.out = idle_level(s.mode.output_polarity);
                    end else if (I_BYTEENABLE[0] && I_WRITEDATA[CMD_GO_BIT]) begin
                        n.run = is_trig_mode ? ST_ARMED : ST_RUN;
                        n.overflow = 1'b0;
                        n.phase = 1'b0;
                        n.out = idle_level(s.mode.output_polarity);
                        n.cnt = s.mode.pulse_train ? phase_len(s.delay_len, mask)
                                                   : 32'h0000_0000;
                    end
                end
                OFS_MODE: begin
                    wmerged = be_merge(32'(s.mode), I_WRITEDATA, I_BYTEENABLE);
                    n.mode = gpec_mode_s'(wmerged[$bits(gpec_mode_s)-1:0]);
                    if (VARIANT24)
                        n.mode.two_counters = 1'b0;
                    n.run = ST_IDLE;
                    n.overflow = 1'b0;
                    n.phase = 1'b0;
                    n.out = idle_level(n.mode.output_polarity);
                end
                OFS_DELAY: n.delay_len = be_merge(s.delay_len, I_WRITEDATA, I_BYTEENABLE);
                OFS_PULSE: n.pulse_len = be_merge(s.pulse_len, I_WRITEDATA, I_BYTEENABLE);
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            s <= STATE_RST;
            s.mode <= MODE_RST;
            s.delay_len <= LEN_RST;
            s.pulse_len <= LEN_RST;
        end else if (I_CE) begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign O_READDATA = s.rdata;
    assign O_WAITREQUEST = s.waitreq;
    assign O_OUT = s.out;

endmodule

// ### tb/gpec_props.sv
`timescale 1ns/1ps
module gpec_props
    import gpec_pkg::*;
#(
    parameter bit VARIANT24  = 1'b0,
    parameter int CHANNEL_ID = 1
) (
    input wire logic        I_CLOCK,       // Clock
    input wire logic        I_ARST_N,      // Reset
    input wire logic        I_CE,          // Enable
    input wire logic [4:0]  I_ADDRESS,     // Address
    input wire logic        I_READ,        // Read
    input wire logic        I_WRITE,       // Write
    input wire logic [31:0] I_WRITEDATA,   // Write data
    input wire logic [3:0]  I_BYTEENABLE,  // Lanes
    input wire logic [31:0] O_READDATA,    // Read data
    input wire logic        O_WAITREQUEST, // Wait
    input wire logic        I_SOURCE,      // Source pin
    input wire logic        I_GATE,        // Gate pin
    input wire logic        O_OUT          // Output pin
);
    localparam int PART = VARIANT24 ? 0 : (CHANNEL_ID % 5 == 0) ? CHANNEL_ID - 4 : CHANNEL_ID + 1;
    logic take;
    logic mode_wr;
    logic halt_wr;
    logic pol;
    assign take    = I_CE && O_WAITREQUEST && (I_READ || I_WRITE);
    assign mode_wr = I_CE && !O_WAITREQUEST && I_WRITE && I_ADDRESS == OFS_MODE;
    assign halt_wr = I_CE && !O_WAITREQUEST && I_WRITE && I_ADDRESS == OFS_CMD
                     && I_WRITEDATA[CMD_HALT_BIT];
    // Idle level follows the last polarity written
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pol <= 1'b0;
        end else if (mode_wr) begin
            pol <= I_WRITEDATA[6];
        end
    end
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_ARST_N);
    property p_take; take |=> !O_WAITREQUEST; endproperty
    a_take: assert property (p_take) else $error("request not answered");
    property p_one; $fell(O_WAITREQUEST) && I_CE |=> O_WAITREQUEST; endproperty
    a_one: assert property (p_one) else $error("wait low too long");
    property p_cause; $fell(O_WAITREQUEST) |-> $past(take); endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    property p_hold; !(take && I_READ) |=> $stable(O_READDATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_ce;
        !I_CE |=> $stable(O_OUT) && $stable(O_WAITREQUEST) && $stable(O_READDATA);
    endproperty
    a_ce: assert property (p_ce) else $error("state moved while frozen");
    property p_cmd0; take && I_READ && I_ADDRESS == OFS_CMD |=> O_READDATA == 32'h0; endproperty
    a_cmd0: assert property (p_cmd0) else $error("command reads nonzero");
    property p_part;
        take && I_READ && I_ADDRESS == OFS_PARTNER |=> O_READDATA == 32'(PART);
    endproperty
    a_part: assert property (p_part) else $error("wrong cascade partner");
    property p_idle; mode_wr || halt_wr |-> ##2 O_OUT == pol; endproperty
    a_idle: assert property (p_idle) else $error("output not at idle level");
    c_mode: cover property (mode_wr);
    c_read: cover property (take && I_READ);
    c_pulse: cover property ($rose(O_OUT));
endmodule
bind gpec_counter gpec_props #(.VARIANT24(VARIANT24), .CHANNEL_ID(CHANNEL_ID)) u_props (
    .I_CLOCK(I_CLOCK), .I_ARST_N(I_ARST_N), .I_CE(I_CE), .I_ADDRESS(I_ADDRESS),
    .I_READ(I_READ), .I_WRITE(I_WRITE), .I_WRITEDATA(I_WRITEDATA),
    .I_BYTEENABLE(I_BYTEENABLE), .O_READDATA(O_READDATA), .O_WAITREQUEST(O_WAITREQUEST),
    .I_SOURCE(I_SOURCE), .I_GATE(I_GATE), .O_OUT(O_OUT)
);

// ### tb/gpec_pins.sv
`timescale 1ns/1ps
module gpec_pins (
    input  wire logic clk,    // Bench clock
    input  wire logic out,    // Pulse output
    output logic      source, // Source pin
    output logic      gate    // Gate pin
);
    logic [15:0] seen;
    initial begin
        source = 1'b0;
        gate   = 1'b0;
        seen   = '0;
    end
    // Settle time covers the pin synchronisers
    task automatic set_gate(input logic lvl);
        @(posedge clk);
        gate <= lvl;
        repeat (8) @(posedge clk);
    endtask
    // Output level is noted before each rising edge
    task automatic burst(input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            seen[k] = out;
            source <= 1'b1;
            repeat (8) @(posedge clk);
            source <= 1'b0;
            repeat (8) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    import gpec_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        ce;
    logic [4:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        wait_req;
    logic        src;
    logic        gate;
    logic        out;
    int          bad_count;
    int          checks;
    logic [31:0] exp_q[$];
    string       name_q[$];
    gpec_counter #(.VARIANT24(1'b0), .CHANNEL_ID(5)) i_gpec_counter (
        .I_CLOCK(clk), .I_ARST_N(rst_n), .I_CE(ce), .I_ADDRESS(addr), .I_READ(rd),
        .I_WRITE(wr), .I_WRITEDATA(wdata), .I_BYTEENABLE(be), .O_READDATA(rdata),
        .O_WAITREQUEST(wait_req), .I_SOURCE(src), .I_GATE(gate), .O_OUT(out)
    );
    gpec_pins u_pins (.clk(clk), .out(out), .source(src), .gate(gate));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Bus master
    // ----------------------------------------
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (n >= 50) begin
            bad_count++;
            summarize();
        end
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdx(input string nm, input logic [4:0] a, input logic [31:0] e);
        name_q.push_back(nm);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    always @(posedge clk) begin
        if (rd && wait_req === 1'b0) begin
            if (exp_q.size() == 0) begin
                chk("spare read", 32'h0, 32'h1);
            end else begin
                chk(name_q.pop_front(), exp_q.pop_front(), rdata);
            end
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] m;
        logic [31:0] seed;
        logic [2:0]  gm;
        logic        init;
        int          dl;
        int          pl;
        logic [15:0] v;
        logic [31:0] ev [5];
        ev = '{32'h7, 32'h3, 32'h4, 32'h3, 32'h3};
        seed = 32'h2f80;
        rst_n = 1'b0;
        ce = 1'b1;
        addr = '0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = '0;
        be = 4'hF;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        rdx("mode", OFS_MODE, 32'h0);
        rdx("delay", OFS_DELAY, LEN_RST);
        rdx("pulse", OFS_PULSE, LEN_RST);
        rdx("status", OFS_STATUS, 32'h0);
        rdx("cmd", OFS_CMD, 32'h0);
        rdx("partner", OFS_PARTNER, 32'h1);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            bus(1'b1, OFS_DELAY, seed);
            rdx("delay rw", OFS_DELAY, seed);
        end
        // Each gate mode: four pulses at first level, three at the other
        for (int g = 0; g < 5; g++) begin
            gm = g[2:0];
            init = (gm == GATE_FALL);
            u_pins.set_gate(init);
            m = {21'h0, 1'b0, gm, 1'b0, SRC_PIN, gm[0], 2'b00};
            bus(1'b1, OFS_MODE, m);
            rdx("mode rw", OFS_MODE, m);
            bus(1'b1, OFS_CMD, 32'h1);
            rdx("armed", OFS_STATUS, (gm >= GATE_RISE) ? 32'h4 : 32'h2);
            u_pins.burst(4);
            u_pins.set_gate(!init);
            u_pins.burst(3);
            rdx("count", OFS_COUNT, ev[g]);
            rdx("count hi", OFS_CNT_HI, 32'h0);
        end
        // Short lengths are raised to three edges
        for (int p = 0; p < 2; p++) begin
            dl = p ? 3 : 4;
            pl = p ? 5 : 3;
            bus(1'b1, OFS_DELAY, p ? 32'h1 : 32'h4);
            bus(1'b1, OFS_PULSE, p ? 32'h5 : 32'h2);
            m = {21'h0, 1'b1, GATE_IGNORED, p[0], SRC_PIN, 1'b0, 2'b00};
            bus(1'b1, OFS_MODE, m);
            bus(1'b1, OFS_CMD, 32'h1);
            repeat (4) @(posedge clk);
            v = '0;
            for (int k = 0; k < 2 * (dl + pl); k++) begin
                v[k] = ((k % (dl + pl)) >= dl) ^ p[0];
            end
            u_pins.burst(2 * (dl + pl));
            chk("phases", {16'h0, v}, {16'h0, u_pins.seen});
            bus(1'b1, OFS_CMD, 32'h2);
            rdx("halted", OFS_STATUS, {28'h0, p[0], 3'b000});
        end
        repeat (4) @(posedge clk);
        chk("reads left", 32'h0, exp_q.size());
        summarize();
    end
endmodule
